// >>> common/audio_pkg.sv
// Purpose: Shared constants and types for the stereo audio serial port
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Fifo index 0/1 = transmit left/right, 2/3 = receive left/right
package audio_pkg;

	// One register port request, sampled on the rising clock edge
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] FRAME_OFS = 8'h04;
	localparam logic [7:0] DIV_OFS   = 8'h08;
	localparam logic [7:0] STAT_OFS  = 8'h0c;
	localparam logic [7:0] MASK_OFS  = 8'h10;
	localparam logic [7:0] LEVEL_OFS = 8'h14;
	localparam logic [7:0] TXL16_OFS = 8'h20;
	localparam logic [7:0] TXR16_OFS = 8'h24;
	localparam logic [7:0] TXL24_OFS = 8'h28;
	localparam logic [7:0] TXR24_OFS = 8'h2c;
	localparam logic [7:0] TXIL_OFS  = 8'h30;
	localparam logic [7:0] TXL2_OFS  = 8'h34;
	localparam logic [7:0] TXR2_OFS  = 8'h38;
	localparam logic [7:0] RXL16_OFS = 8'h40;
	localparam logic [7:0] RXR16_OFS = 8'h44;
	localparam logic [7:0] RXL24_OFS = 8'h48;
	localparam logic [7:0] RXR24_OFS = 8'h4c;
	localparam logic [7:0] RXIL_OFS  = 8'h50;
	localparam logic [7:0] RXL2_OFS  = 8'h54;
	localparam logic [7:0] RXR2_OFS  = 8'h58;

	// Control field positions and reset values
	localparam int          CTRL_TX_EN = 0;
	localparam int          CTRL_RX_EN = 1;
	localparam int          CTRL_RX_MS = 2;
	localparam int          CTRL_WL_LO = 3;
	localparam logic [4:0]  CTRL_RST   = 5'h00;
	localparam logic [5:0]  FRAME_RST  = 6'h1f;
	localparam logic [7:0]  DIV_RST    = 8'h03;

	// Word length codes and lengths
	localparam logic [1:0]  WL16 = 2'h0;
	localparam logic [1:0]  WL18 = 2'h1;
	localparam logic [1:0]  WL20 = 2'h2;
	localparam logic [4:0]  LEN16 = 5'h10;
	localparam logic [4:0]  LEN18 = 5'h12;
	localparam logic [4:0]  LEN20 = 5'h14;
	localparam logic [4:0]  LEN24 = 5'h18;

	// Event bit positions inside each fifo's five-bit group
	localparam int EV_UNDER = 0;
	localparam int EV_OVER  = 1;
	localparam int EV_FULL  = 2;
	localparam int EV_HALF  = 3;
	localparam int EV_NEMP  = 4;
	localparam int EV_W     = 5;

	// Fifo geometry
	localparam int         NFIFO      = 4;
	localparam logic [3:0] FIFO_DEPTH = 4'h4;
	localparam logic [2:0] FIFO_HALF  = 3'h2;

endpackage

// >>> src/stereo_audio_serial_port.sv
// Purpose: Stereo audio serial port, transmit and receive, with sample fifos
// Assumes: Link pins sampled by i_mclk; bit clock half period >= 3 mclk
// Notes:   Bit clock made by dividing i_mclk, shared by transmit and receive master
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module stereo_audio_serial_port (
	input  wire logic               i_mclk,      // System clock
	input  wire logic               i_resetn,    // Synchronous reset, low
	input  wire audio_pkg::bus_req_s i_bus,      // Register request
	output logic [31:0]             o_rdata,     // Read data, cycle after
	output logic                    o_irq,       // Interrupt level
	output logic [3:0]              o_dma_req,   // DMA request per fifo
	output logic                    o_tx_sck,    // Transmit bit clock
	output logic                    o_tx_ws,     // Transmit word select
	output logic                    o_tx_sd,     // Transmit data
	input  wire logic               i_rx_sck_i,  // Receive bit clock in
	output logic                    o_rx_sck_o,  // Receive bit clock out
	output logic                    o_rx_sck_oe, // Receive bit clock enable
	input  wire logic               i_rx_ws_i,   // Receive word select in
	output logic                    o_rx_ws_o,   // Receive word select out
	output logic                    o_rx_ws_oe,  // Receive word select enable
	input  wire logic               i_rx_sd      // Receive data
);
	import audio_pkg::*;

	// Word length decode, used by both directions
	function automatic logic [4:0] wl_len(input logic [1:0] code);
		return (code == WL16) ? LEN16 : (code == WL18) ? LEN18 :
			(code == WL20) ? LEN20 : LEN24;
	endfunction

	// Room for n more entries
	function automatic logic fits(input logic [2:0] c, input logic [1:0] n);
		return ({1'b0, c} + {2'h0, n}) <= FIFO_DEPTH;
	endfunction

	// At least n entries held
	function automatic logic holds(input logic [2:0] c, input logic [1:0] n);
		return c >= {1'b0, n};
	endfunction

	// Registers
	logic [4:0]  ctrl_q;                // Enables, mode, word length
	logic [5:0]  frame_q;               // Bits per half period minus one
	logic [7:0]  div_q;                 // Mclk cycles per bit clock half, minus one
	logic [19:0] stat_q;                // Sticky events
	logic [19:0] mask_q;                // Interrupt mask
	logic [19:0] level;                 // Live fifo flags
	logic [19:0] ev;                    // Event inputs to status
	logic [31:0] rdata_d;               // Read mux

	// Fifo storage and pointers
	logic [23:0] mem_q [NFIFO][4];      // Sample storage
	logic [1:0]  wp_q  [NFIFO];         // Write pointers
	logic [1:0]  rp_q  [NFIFO];         // Read pointers
	logic [2:0]  cnt_q [NFIFO];         // Fill counts
	logic [1:0]  push_n [NFIFO];        // Entries pushed this cycle
	logic [1:0]  pop_n  [NFIFO];        // Entries popped this cycle
	logic [23:0] din0 [NFIFO];          // First pushed word
	logic [23:0] din1 [NFIFO];          // Second pushed word
	logic [23:0] head0 [NFIFO];         // Oldest entry
	logic [23:0] head1 [NFIFO];         // Next oldest

	// Bus request fields
	wire logic [7:0]  a  = i_bus.addr;
	wire logic [31:0] w  = i_bus.wdata;
	wire logic        wr = i_bus.wr;
	wire logic        rd = i_bus.rd;

	// Control fields
	wire logic       tx_en = ctrl_q[CTRL_TX_EN];
	wire logic       rx_en = ctrl_q[CTRL_RX_EN];
	wire logic       rx_ms = ctrl_q[CTRL_RX_MS];
	wire logic [4:0] wlen  = wl_len(ctrl_q[CTRL_WL_LO +: 2]);

	// Transmit sample writes: count wanted per channel
	wire logic       is_txil = (a == TXIL_OFS);
	wire logic [1:0] txl_want = (a == TXL16_OFS || a == TXL24_OFS || is_txil) ? 2'h1 :
		(a == TXL2_OFS) ? 2'h2 : 2'h0;
	wire logic [1:0] txr_want = (a == TXR16_OFS || a == TXR24_OFS || is_txil) ? 2'h1 :
		(a == TXR2_OFS) ? 2'h2 : 2'h0;
	// Interleaved pair only goes in whole; a write with no room is dropped
	wire logic       il_room = fits(cnt_q[0], 2'h1) && fits(cnt_q[1], 2'h1);
	wire logic       txl_ok = wr && (is_txil ? il_room : fits(cnt_q[0], txl_want));
	wire logic       txr_ok = wr && (is_txil ? il_room : fits(cnt_q[1], txr_want));

	// Receive sample reads: count wanted per channel
	wire logic       is_rxil = (a == RXIL_OFS);
	wire logic [1:0] rxl_want = (a == RXL16_OFS || a == RXL24_OFS || is_rxil) ? 2'h1 :
		(a == RXL2_OFS) ? 2'h2 : 2'h0;
	wire logic [1:0] rxr_want = (a == RXR16_OFS || a == RXR24_OFS || is_rxil) ? 2'h1 :
		(a == RXR2_OFS) ? 2'h2 : 2'h0;
	wire logic       il_avail = holds(cnt_q[2], 2'h1) && holds(cnt_q[3], 2'h1);
	wire logic       rxl_ok = rd && (is_rxil ? il_avail : holds(cnt_q[2], rxl_want));
	wire logic       rxr_ok = rd && (is_rxil ? il_avail : holds(cnt_q[3], rxr_want));

	// Bit clock generator state
	logic       gen_en;                 // Generator running
	logic [7:0] dcnt_q;                 // Divider count
	logic       sck_q;                  // Generated bit clock
	logic       ws_q;                   // Generated word select
	logic [5:0] bcnt_q;                 // Bit within half period
	logic       tick;                   // Bit clock edge due
	logic       fall;                   // Falling bit clock edge
	logic       half_start;             // New half period begins
	logic       new_ch;                 // Channel of the new half, 1 = right

	// Transmit datapath
	logic [23:0] txw_q;                 // Word in flight
	logic        sd_q;                  // Serial data flop
	logic        tx_load;               // Fetch at half start
	logic        tx_empty;              // Needed fifo is empty
	logic [23:0] tx_next;               // Word for the coming bit
	logic [5:0]  nb;                    // Next bit number
	logic [5:0]  idx;                   // Bit index from the LSB end

	// Receive datapath
	logic [1:0]  sck_s, ws_s, sd_s;     // Pin synchronisers
	logic        rsck_prev_q;           // Last seen receive clock
	logic        rws_last_q;            // Word select at last rising edge
	logic        armed_q;               // First change to the left half seen
	logic [23:0] rsh_q;                 // Receive shift register
	logic        rsck, rws, rrise;      // Selected clock, select, rise
	logic        rx_done;               // Word complete this cycle
	logic [23:0] rx_word;               // Completed word, masked

	// Generator runs for transmit or receive master
	assign gen_en     = tx_en || (rx_en && rx_ms);
	assign tick       = (dcnt_q == div_q);
	assign fall       = tick && sck_q;
	assign half_start = fall && (bcnt_q == frame_q);
	assign new_ch     = ~ws_q;

	// Divider, bit clock and word select; select changes on falling edge
	always_ff @(posedge i_mclk) begin
		if (!i_resetn || !gen_en) begin
			dcnt_q <= 8'h00;
			sck_q  <= 1'b0;
			ws_q   <= 1'b0;
			bcnt_q <= 6'h00;
		end else begin
			dcnt_q <= tick ? 8'h00 : dcnt_q + 8'h01;
			sck_q  <= sck_q ^ tick;
			ws_q   <= ws_q ^ half_start;
			if (fall)
				bcnt_q <= half_start ? 6'h00 : bcnt_q + 6'h01;
		end
	end

	// Transmit fetch; an empty fifo sends silence
	assign tx_empty = new_ch ? (cnt_q[1] == 3'h0) : (cnt_q[0] == 3'h0);
	assign tx_load  = half_start && tx_en;
	assign tx_next  = !half_start ? txw_q : tx_empty ? 24'h000000 :
		(new_ch ? head0[1] : head0[0]);
	assign nb       = half_start ? 6'h00 : bcnt_q + 6'h01;
	assign idx      = frame_q - nb;

	// Data shifts MSB first, word ends at the select change
	always_ff @(posedge i_mclk) begin
		if (!i_resetn || !tx_en) begin
			txw_q <= 24'h000000;
			sd_q  <= 1'b0;
		end else if (fall) begin
			txw_q <= tx_next;
			// Bits ahead of the word are padded with zero
			sd_q  <= ({1'b0, wlen} > idx) && tx_next[idx[4:0]];
		end
	end

	assign o_tx_sck = sck_q;
	assign o_tx_ws  = ws_q;
	assign o_tx_sd  = sd_q;

	// Receive pins pass two flops before use
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			sck_s <= 2'h0;
			ws_s  <= 2'h0;
			sd_s  <= 2'h0;
		end else begin
			sck_s <= {sck_s[0], i_rx_sck_i};
			ws_s  <= {ws_s[0], i_rx_ws_i};
			sd_s  <= {sd_s[0], i_rx_sd};
		end
	end

	// Master uses own clocks, slave the synchronised pins
	assign rsck  = rx_ms ? sck_q : sck_s[1];
	assign rws   = rx_ms ? ws_q : ws_s[1];
	assign rrise = rx_en && rsck && !rsck_prev_q;
	// Select change seen at a rising edge closes the previous word
	assign rx_done = rrise && (rws != rws_last_q) && armed_q;
	assign rx_word = rsh_q & ~(24'hffffff << wlen);

	// Receive shifter; capture opens at the first left half after enable
	always_ff @(posedge i_mclk) begin
		if (!i_resetn || !rx_en) begin
			rsck_prev_q <= 1'b0;
			rws_last_q  <= 1'b0;
			armed_q     <= 1'b0;
			rsh_q       <= 24'h000000;
		end else begin
			rsck_prev_q <= rsck;
			if (rrise) begin
				rws_last_q <= rws;
				armed_q    <= armed_q || (rws != rws_last_q && !rws); // Pin may idle high
				rsh_q      <= (rws != rws_last_q) ? {23'h000000, sd_s[1]} :
					{rsh_q[22:0], sd_s[1]};
			end
		end
	end

	assign o_rx_sck_o  = sck_q;
	assign o_rx_sck_oe = rx_ms;
	assign o_rx_ws_o   = ws_q;
	assign o_rx_ws_oe  = rx_ms;

	// Fifo inputs: bus fills transmit, link fills receive
	assign push_n[0] = txl_ok ? txl_want : 2'h0;
	assign push_n[1] = txr_ok ? txr_want : 2'h0;
	assign din0[0]   = (a == TXL24_OFS) ? w[23:0] : {8'h00, w[15:0]};
	assign din1[0]   = {8'h00, w[31:16]};
	assign din0[1]   = (a == TXR24_OFS) ? w[23:0] :
		is_txil ? {8'h00, w[31:16]} : {8'h00, w[15:0]};
	assign din1[1]   = {8'h00, w[31:16]};
	assign pop_n[0]  = {1'b0, tx_load && !new_ch && !tx_empty};
	assign pop_n[1]  = {1'b0, tx_load && new_ch && !tx_empty};
	assign push_n[2] = {1'b0, rx_done && !rws_last_q && fits(cnt_q[2], 2'h1)};
	assign push_n[3] = {1'b0, rx_done && rws_last_q && fits(cnt_q[3], 2'h1)};
	assign din0[2]   = rx_word;
	assign din0[3]   = rx_word;
	assign din1[2]   = 24'h000000;
	assign din1[3]   = 24'h000000;
	assign pop_n[2]  = rxl_ok ? rxl_want : 2'h0;
	assign pop_n[3]  = rxr_ok ? rxr_want : 2'h0;

	// Four identical fifos, one per channel and direction
	for (genvar f = 0; f < NFIFO; f++) begin : g_fifo
		assign head0[f] = mem_q[f][rp_q[f]];
		assign head1[f] = mem_q[f][rp_q[f] + 2'h1];

		// Storage, no reset needed
		always_ff @(posedge i_mclk) begin
			if (push_n[f] != 2'h0)
				mem_q[f][wp_q[f]] <= din0[f];
			if (push_n[f] == 2'h2)
				mem_q[f][wp_q[f] + 2'h1] <= din1[f];
		end

		// Pointers and count; depth four stereo samples
		always_ff @(posedge i_mclk) begin
			if (!i_resetn) begin
				wp_q[f]  <= 2'h0;
				rp_q[f]  <= 2'h0;
				cnt_q[f] <= 3'h0;
			end else begin
				wp_q[f]  <= wp_q[f] + push_n[f];
				rp_q[f]  <= rp_q[f] + pop_n[f];
				cnt_q[f] <= cnt_q[f] + {1'b0, push_n[f]} - {1'b0, pop_n[f]};
			end
		end

		// Live flags per channel
		assign level[f*EV_W + EV_UNDER] = 1'b0;
		assign level[f*EV_W + EV_OVER]  = 1'b0;
		assign level[f*EV_W + EV_FULL]  = ({1'b0, cnt_q[f]} == FIFO_DEPTH);
		assign level[f*EV_W + EV_HALF]  = (cnt_q[f] >= FIFO_HALF);
		assign level[f*EV_W + EV_NEMP]  = (cnt_q[f] != 3'h0);
		assign ev[f*EV_W +: EV_W] = level[f*EV_W +: EV_W] |
			(f < 2 ? {4'h0, tx_load && tx_empty && (new_ch == (f == 1))} :
			{3'h0, rx_done && (rws_last_q == (f == 3)) && !fits(cnt_q[f], 2'h1), 1'b0});
		// Transmit asks for space, receive for data
		assign o_dma_req[f] = (f < 2) ? fits(cnt_q[f], 2'h1) : level[f*EV_W + EV_NEMP];
	end

	// Register writes; an event wins over its own clear
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			ctrl_q  <= CTRL_RST;
			frame_q <= FRAME_RST;
			div_q   <= DIV_RST;
			stat_q  <= 20'h00000;
			mask_q  <= 20'h00000;
		end else begin
			if (wr && a == CTRL_OFS)
				ctrl_q <= w[4:0];
			if (wr && a == FRAME_OFS)
				frame_q <= w[5:0];
			if (wr && a == DIV_OFS)
				div_q <= w[7:0];
			if (wr && a == MASK_OFS)
				mask_q <= w[19:0];
			stat_q <= (stat_q & ~((wr && a == STAT_OFS) ? w[19:0] : 20'h00000)) | ev;
		end
	end

	// Read mux; receive data words pop as they are read
	assign rdata_d =
		(a == CTRL_OFS)  ? {27'h0000000, ctrl_q} :
		(a == FRAME_OFS) ? {26'h0000000, frame_q} :
		(a == DIV_OFS)   ? {24'h000000, div_q} :
		(a == STAT_OFS)  ? {12'h000, stat_q} :
		(a == MASK_OFS)  ? {12'h000, mask_q} :
		(a == LEVEL_OFS) ? {12'h000, level} :
		(a == RXL16_OFS && rxl_ok) ? {16'h0000, head0[2][15:0]} :
		(a == RXR16_OFS && rxr_ok) ? {16'h0000, head0[3][15:0]} :
		(a == RXL24_OFS && rxl_ok) ? {8'h00, head0[2]} :
		(a == RXR24_OFS && rxr_ok) ? {8'h00, head0[3]} :
		(is_rxil && rxl_ok) ? {head0[3][15:0], head0[2][15:0]} :
		(a == RXL2_OFS && rxl_ok) ? {head1[2][15:0], head0[2][15:0]} :
		(a == RXR2_OFS && rxr_ok) ? {head1[3][15:0], head0[3][15:0]} :
		32'h00000000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (!i_resetn)
			o_rdata <= 32'h00000000;
		else
			o_rdata <= rd ? rdata_d : 32'h00000000;
	end

	assign o_irq = |(stat_q & mask_q);

	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	a_ws_on_fall: assert property ($changed(ws_q) && $past(gen_en) |-> $fell(sck_q))
		else $error("word select moved off a falling edge");
	a_tx_idle: assert property (!gen_en |=> !o_tx_sck && !o_tx_ws)
		else $error("transmit clocks run while stopped");
	a_rx_slave: assert property (!rx_ms |-> !o_rx_sck_oe && !o_rx_ws_oe)
		else $error("slave receive drives its clocks");
	a_fifo_bound: assert property ({1'b0, cnt_q[2]} <= FIFO_DEPTH &&
		{1'b0, cnt_q[0]} <= FIFO_DEPTH)
		else $error("fifo count beyond depth");
	a_underrun_set: assert property (tx_load && tx_empty && !new_ch |=>
		stat_q[EV_UNDER] ##1 (stat_q[EV_UNDER] || $past(wr && a == STAT_OFS && w[EV_UNDER])))
		else $error("underrun not held");
	a_overrun_set: assert property (rx_done && !rws_last_q && cnt_q[2] == 3'h4
		|=> stat_q[2*EV_W + EV_OVER])
		else $error("overrun not flagged");
	a_irq_mask: assert property (o_irq |-> |(stat_q & mask_q) && mask_q != 20'h00000)
		else $error("interrupt without unmasked status");
	a_pad_zero: assert property (fall && tx_en && ({1'b0, wlen} <= idx) |=> !o_tx_sd)
		else $error("pad bit not zero");
	a_il_push: assert property (wr && is_txil && il_room && pop_n[0] == 2'h0
		|=> cnt_q[0] == $past(cnt_q[0]) + 3'h1)
		else $error("interleaved write lost");

	c_underrun: cover property (tx_load && tx_empty);
	c_overrun: cover property (rx_done && !fits(cnt_q[3], 2'h1));
	c_packed: cover property (wr && a == TXL2_OFS && txl_ok);
	c_rx_word: cover property (push_n[2] != 2'h0);

endmodule

// >>> verif/codec_model.sv
// Purpose: Codec model on the far side of the audio link
// Assumes: Words fit in 32 bits, one word per half
// Notes:   Zero transmit words are idle or underrun halves and are not kept
`timescale 1ns/1ps
module codec_model (
	input  wire logic        i_mst,    // Model leads the receive clocks
	input  wire logic [6:0]  i_nb,     // Bits per half
	input  wire logic [31:0] i_lw,     // Left word to send
	input  wire logic [31:0] i_rw,     // Right word to send
	input  wire logic        i_sck,    // Resolved receive bit clock
	input  wire logic        i_ws,     // Resolved receive word select
	output logic             o_sck,    // Bit clock when leading
	output logic             o_ws,     // Word select when leading
	output logic             o_sd,     // Receive data
	input  wire logic        i_tx_sck, // Transmit bit clock
	input  wire logic        i_tx_ws,  // Transmit word select
	input  wire logic        i_tx_sd   // Transmit data
);
	logic [31:0] cap_l[$];      // Left words seen
	logic [31:0] cap_r[$];      // Right words seen
	logic [31:0] sh = 32'h0;    // Transmit shifter
	logic [31:0] w;             // Word being sent
	logic        lws = 1'b0;    // Last transmit word select
	logic        rws = 1'b0;    // Last receive word select
	int          cnt = 0;       // Bits in current half
	int          idx = 0;       // Bit index being sent
	int          p;             // Bit position in word
	initial begin
		o_sck = 1'b0;
		o_ws  = 1'b0;
		o_sd  = 1'b0;
	end
	// 64 ns bit clock, still while the device leads
	always #32 if (i_mst) o_sck = ~o_sck;
	// Word select flips after a whole half
	always @(negedge o_sck) begin
		cnt = (cnt >= i_nb - 1) ? 0 : cnt + 1;
		if (cnt == 0) o_ws = ~o_ws;
	end
	// Data moves on the falling clock, LSB last in the half
	always @(negedge i_sck) begin
		#1;
		if (i_ws !== rws) begin
			idx = 0;
			rws = i_ws;
		end
		w = rws ? i_rw : i_lw;
		p = i_nb - 1 - idx;
		o_sd = (p >= 0 && p < 32) ? w[p] : 1'b0;
		idx++;
	end
	// Word ends on the bit before word select flips
	always @(posedge i_tx_sck) begin
		if (i_tx_ws !== lws) begin
			if (sh != 32'h0 && lws) cap_r.push_back(sh);
			if (sh != 32'h0 && !lws) cap_l.push_back(sh);
			sh = {31'h0, i_tx_sd};
			lws = i_tx_ws;
		end else begin
			sh = {sh[30:0], i_tx_sd};
		end
	end
endmodule

// >>> verif/stereo_audio_serial_port_tb.sv
// Purpose: Self-checking bench for the stereo audio serial port
// Assumes: Register port driven just after rising edges
// Notes:   Expected words kept in queues and compared in order
`timescale 1ns/1ps
module stereo_audio_serial_port_tb;
	import audio_pkg::*;
	logic        mclk, resetn, irq;          // Clock, reset, interrupt
	bus_req_s    bus;                        // Register request
	logic [31:0] rdata, d, v, u, lw, rw;     // Read data and words
	logic [3:0]  dma;                        // DMA requests
	logic        tsck, tws, tsd, sd, mst;    // Link pins
	logic        rsck_o, rsck_oe, rws_o, rws_oe, msck, mws;
	wire         rsck = rsck_oe ? rsck_o : msck; // Whoever enables drives
	wire         rws  = rws_oe ? rws_o : mws;
	logic [6:0]  nb;                         // Bits per half
	logic [1:0]  wl;                         // Word length code
	logic        ms;                         // Device leads receive
	logic [31:0] el[$], er[$];               // Expected transmit words
	int          bad_count, num_checks, seed, cyc, m, k, i;
	stereo_audio_serial_port u_dut (
		.i_mclk(mclk), .i_resetn(resetn), .i_bus(bus), .o_rdata(rdata),
		.o_irq(irq), .o_dma_req(dma), .o_tx_sck(tsck), .o_tx_ws(tws),
		.o_tx_sd(tsd), .i_rx_sck_i(rsck), .o_rx_sck_o(rsck_o),
		.o_rx_sck_oe(rsck_oe), .i_rx_ws_i(rws), .o_rx_ws_o(rws_o),
		.o_rx_ws_oe(rws_oe), .i_rx_sd(sd));
	codec_model u_codec (
		.i_mst(mst), .i_nb(nb), .i_lw(lw), .i_rw(rw), .i_sck(rsck),
		.i_ws(rws), .o_sck(msck), .o_ws(mws), .o_sd(sd),
		.i_tx_sck(tsck), .i_tx_ws(tws), .i_tx_sd(tsd));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Hang guard, well above the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// One strobe cycle; read data taken in the answer cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] x);
		bus <= '{addr: a, wdata: x, wr: w, rd: ~w};
		@(posedge mclk);
		bus <= '{addr: 8'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		acc(1'b0, a, 32'h0);
		chk(d, x);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	initial begin
		seed = 32'hec58;
		bus = '0;
		resetn = 1'b0;
		mst = 1'b0;
		nb = 7'd24;
		lw = 32'h0;
		rw = 32'h0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		#1;
		chk({28'h0, dma}, 32'h3);
		rchk(CTRL_OFS, {27'h0, CTRL_RST});
		rchk(FRAME_OFS, {26'h0, FRAME_RST});
		rchk(DIV_OFS, {24'h0, DIV_RST});
		rchk(8'hfc, 32'h0);
		// Transmit: fill while stopped, then compare words on the wire
		acc(1'b1, FRAME_OFS, 32'd23);
		for (m = 0; m < 4; m++) begin
			wl = (m == 1) ? 2'h3 : 2'h0;
			acc(1'b1, CTRL_OFS, {27'h0, wl, 3'h0});
			u_codec.cap_l.delete();
			u_codec.cap_r.delete();
			for (k = 0; k < ((m == 1) ? 5 : (m == 3) ? 2 : 4); k++) begin
				v = $random(seed) | 32'h00010001;
				u = $random(seed) | 32'h00010001;
				case (m)
					0: begin
						acc(1'b1, TXL16_OFS, v);
						acc(1'b1, TXR16_OFS, u);
						el.push_back(v & 32'hffff);
						er.push_back(u & 32'hffff);
					end
					1: begin
						acc(1'b1, TXL24_OFS, v);
						acc(1'b1, TXR24_OFS, u);
						if (k < 4) el.push_back(v & 32'hffffff); // Fifth is refused
						if (k < 4) er.push_back(u & 32'hffffff);
					end
					2: begin
						acc(1'b1, TXIL_OFS, v);
						el.push_back(v & 32'hffff);
						er.push_back(v >> 16);
					end
					default: begin
						acc(1'b1, TXL2_OFS, v);
						acc(1'b1, TXR2_OFS, u);
						el.push_back(v & 32'hffff);
						el.push_back(v >> 16);
						er.push_back(u & 32'hffff);
						er.push_back(u >> 16);
					end
				endcase
			end
			if (m == 1) begin
				chk({30'h0, dma[1:0]}, 32'h0);
				acc(1'b0, LEVEL_OFS, 32'h0);
				chk({26'h0, d[9:7], d[4:2]}, 32'h3f);
			end
			acc(1'b1, CTRL_OFS, {27'h0, wl, 3'h1});
			for (k = 0; k < 4000; k++) begin
				if (u_codec.cap_l.size() >= el.size() && u_codec.cap_r.size() >= er.size()) break;
				pause(1);
			end
			while (el.size() > 0) chk(u_codec.cap_l.pop_front(), el.pop_front());
			while (er.size() > 0) chk(u_codec.cap_r.pop_front(), er.pop_front());
			pause(400);
			chk({30'h0, dma[1:0]}, 32'h3);
		end
		// Underrun is sticky, masked into the interrupt, cleared by one
		acc(1'b1, CTRL_OFS, 32'h0);
		acc(1'b0, STAT_OFS, 32'h0);
		chk({30'h0, d[5], d[0]}, 32'h3);
		acc(1'b1, MASK_OFS, 32'h1);
		pause(1);
		chk({31'h0, irq}, 32'h1);
		acc(1'b1, MASK_OFS, 32'h0);
		pause(1);
		chk({31'h0, irq}, 32'h0);
		acc(1'b1, MASK_OFS, 32'h21);
		acc(1'b1, STAT_OFS, 32'h1);
		pause(1);
		chk({31'h0, irq}, 32'h1);
		acc(1'b1, STAT_OFS, 32'h20);
		pause(1);
		chk({31'h0, irq}, 32'h0);
		// Receive: every word length, both clock roles
		for (i = 0; i < 4; i++) begin
			wl = 2'(3 - i);
			ms = i[0];
			nb = (i == 0) ? 7'd64 : 7'd24;
			lw = $random(seed) & 32'hffffff;
			rw = $random(seed) & 32'hffffff;
			acc(1'b1, CTRL_OFS, 32'h0);
			acc(1'b1, FRAME_OFS, {25'h0, nb - 7'd1});
			repeat (4) acc(1'b0, RXL24_OFS, 32'h0);
			repeat (4) acc(1'b0, RXR24_OFS, 32'h0);
			rchk(RXL24_OFS, 32'h0);
			acc(1'b1, STAT_OFS, 32'hfffff);
			mst = ~ms;
			acc(1'b1, CTRL_OFS, {27'h0, wl, ms, 2'h2});
			pause(2);
			chk({31'h0, rsck_oe}, {31'h0, ms});
			pause(14 * nb * 8);
			acc(1'b0, STAT_OFS, 32'h0);
			chk({22'h0, d[19:10]}, 32'h3de);
			chk({30'h0, dma[3:2]}, 32'h3);
			u = (wl == 2'h3) ? 32'hffffff : (32'h1 << (16 + 2 * wl)) - 32'h1;
			rchk(RXL24_OFS, lw & u);
			rchk(RXR24_OFS, rw & u);
		end
		rchk(RXIL_OFS, {rw[15:0], lw[15:0]});
		rchk(RXL2_OFS, {lw[15:0], lw[15:0]});
		rchk(RXR2_OFS, {rw[15:0], rw[15:0]});
		pause(4 * nb * 8); // Receive still runs, so fresh words refill both fifos
		rchk(RXL16_OFS, {16'h0, lw[15:0]});
		rchk(RXR16_OFS, {16'h0, rw[15:0]});
		end_sim();
	end
endmodule
